// [aiss_top.sv]
`timescale 1ns/1ps
module aiss_top (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // shared bus arbitration (bit per bus: p1x,p1y,..,p4x,p4y)
   input  wire logic [7:0]  other_bus_req,
   output logic      [7:0]  shared_bus_req,
   output logic      [7:0]  shared_bus_grant,
   // converter mux drive
   output logic      [7:0]  positive_input_mux,
   output logic      [7:0]  negative_input_mux,
   output logic             result_invert,
   output logic             conv_start,
   // converter result
   input  wire logic        conv_done,
   input  wire logic [11:0] conv_data
);
   // register state
   logic [31:0] single_ctrl_ff;        // single_channel_control
   logic [1:0]  scan_ctrl_ff;          // differential_select, start
   logic [31:0] scan_group_map_ff;     // four 8-bit group selects
   logic [31:0] scan_enable_mask_ff;   // one bit per slot
   logic [15:0] scan_negative_remap_ff;// eight 2-bit remaps
   logic [7:0]  master_dis_ff;         // shared_bus_master_disable
   logic        neg_conf_ff;           // negative_select_conflict
   logic        bus_conf_ff;           // shared_bus_conflict
   logic        done_ff;               // scan complete
   logic [16:0] result_ff;             // slot index + data
   // ahb address phase capture
   logic        wr_ff;
   logic        rd_ff;
   logic [7:0]  addr_ff;
   // sequencer
   aiss_pkg::aiss_state_t state_ff;
   logic [4:0]  slot_ff;
   logic [3:0]  cnt_ff;
   logic        started_ff;

   // classify a select: returns {valid, is_y, bus index[2:0]}
   function automatic logic [4:0] classify(input logic [7:0] s);
      logic [2:0] port;
      logic       odd;
      logic       y;
      port = s[7:5];
      odd  = s[0];
      y    = 1'b0;
      if (port == 3'd1 || port == 3'd3)
         y = odd;
      else if (port == 3'd2 || port == 3'd4)
         y = ~odd;
      else if (port == 3'd0)
         y = s[4];                              // dedicated x 0-15, y 16-31
      classify = {(port <= 3'd4) && (s != aiss_pkg::SEL_GROUND),
                  y, port};
   endfunction : classify

   // slot to physical select (port/channel)
   function automatic logic [7:0] slot_sel(input logic [4:0] sl,
                                           input logic [31:0] gm);
      logic [7:0] g;
      g = gm[{sl[4:3], 3'b000} +: 8];
      // group code: [7:5] port, [1:0] block of eight
      slot_sel = {g[7:5], g[1:0], sl[2:0]};
   endfunction : slot_sel

   // ahb address phase
   wire accept = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff   <= 1'b0;
         rd_ff   <= 1'b0;
         addr_ff <= 8'h00;
      end else begin
         wr_ff   <= accept & hwrite;
         rd_ff   <= accept & ~hwrite;
         addr_ff <= haddr[7:0];
      end
   end
   // zero wait, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // active selections: single or current scan slot
   logic [7:0] cur_pos;
   logic [7:0] cur_neg;
   logic       cur_differential_select;
   logic [7:0] pair_sel;
   logic [1:0] rm;
   always_comb begin
      cur_pos  = single_ctrl_ff[aiss_pkg::POS_LSB +: 8];
      cur_neg  = single_ctrl_ff[aiss_pkg::NEG_LSB +: 8];
      cur_differential_select = single_ctrl_ff[aiss_pkg::DIFFERENTIAL_SELECT_BIT];
      pair_sel = 8'h00;
      rm       = scan_negative_remap_ff[{slot_ff[3:1], 1'b0} +: 2];
      if (state_ff != aiss_pkg::AISS_IDLE) begin
         cur_differential_select = scan_ctrl_ff[aiss_pkg::SCAN_DIFFERENTIAL_SELECT_BIT];
         cur_pos  = slot_sel(slot_ff, scan_group_map_ff);
         if (slot_ff == 5'd15)
            pair_sel = slot_sel(5'd8, scan_group_map_ff);
         else if (cur_pos[4:0] == 5'd31)
            pair_sel = {cur_pos[7:5], 5'd0};
         else
            pair_sel = {cur_pos[7:5], cur_pos[4:0] + 5'd1};
         // remap: even slots of group 0, odd slots of group 1
         if (slot_ff[4:3] == 2'd0 && !slot_ff[0] && rm != 2'd0)
            pair_sel = slot_sel({2'd0, rm, 1'b1} - 5'd2,
                                scan_group_map_ff);
         else if (slot_ff[4:3] == 2'd1 && slot_ff[0] && rm != 2'd0)
            pair_sel = slot_sel({2'd1, rm - 2'd1, 1'b0},
                                scan_group_map_ff);
         cur_neg = cur_differential_select ? pair_sel : aiss_pkg::SEL_GROUND;
      end
   end
   // remap code 0 keeps default; codes 1..3 pick partner slot 1..3 of
   // the odd (or even) set, so partner 7 (or 14) is unreachable by design

   // classification of both inputs
   wire [4:0] pc = classify(cur_pos);
   wire [4:0] nc = classify(cur_neg);

   // mux steering: X side to positive, Y side to negative
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         positive_input_mux <= 8'h00;
         negative_input_mux <= aiss_pkg::SEL_GROUND;
         result_invert      <= 1'b0;
      end else begin
         // swap so that a y positive input lands on the negative mux, unless the negative input is a valid y too
         if (pc[3] && !(nc[4] && nc[3])) begin
            positive_input_mux <= cur_neg;
            negative_input_mux <= cur_pos;
         end else begin
            positive_input_mux <= cur_pos;
            negative_input_mux <= cur_neg;
         end
         // single-ended y, or differential_select y/x, gives inverted result
         result_invert <= cur_differential_select ? (pc[3] & nc[4] & ~nc[3])
                                   : pc[3];
      end
   end

   // shared bus requests per selection, held while selected
   logic [7:0] req;
   always_comb begin
      req = 8'h00;
      // port zero is dedicated, never requested
      if (pc[4] && pc[2:0] != 3'd0)
         req[{pc[1:0] - 2'd1, pc[3]}] = 1'b1;
      if (nc[4] && nc[2:0] != 3'd0 && cur_differential_select)
         req[{nc[1:0] - 2'd1, nc[3]}] = 1'b1;
      if (pc[2:0] == 3'd4)
         req[{2'd3, pc[3]}] = 1'b1;
      if (nc[2:0] == 3'd4 && cur_differential_select)
         req[{2'd3, nc[3]}] = 1'b1;
   end
   // passive buses are not requested
   assign shared_bus_req = req & ~master_dis_ff;
   // contested bus floats
   wire [7:0] contest = shared_bus_req & other_bus_req;
   assign shared_bus_grant = shared_bus_req & ~contest;

   // negative conflict: both inputs from same sub-bus side
   wire neg_bad = cur_differential_select & pc[4] & nc[4] & (pc[3] == nc[3]);
   wire st_wr   = wr_ff && addr_ff == aiss_pkg::OFS_STATUS;

   // status flags: set wins over write-one clear for bus conflict, clear wins for negative conflict
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         neg_conf_ff <= 1'b0;
         bus_conf_ff <= 1'b0;
      end else begin
         // clear lasts one cycle then condition sets it again
         if (st_wr && hwdata[aiss_pkg::ST_NEGCONF])
            neg_conf_ff <= 1'b0;
         else if (neg_bad)
            neg_conf_ff <= 1'b1;
         if (|contest)
            bus_conf_ff <= 1'b1;
         else if (st_wr && hwdata[aiss_pkg::ST_SHARED_BUS_CONFLICT])
            bus_conf_ff <= 1'b0;
      end
   end

   // register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         single_ctrl_ff         <= aiss_pkg::RST_SINGLE;
         scan_group_map_ff      <= aiss_pkg::RST_ZERO;
         scan_enable_mask_ff    <= aiss_pkg::RST_ZERO;
         scan_negative_remap_ff <= 16'h0000;
         master_dis_ff          <= 8'h00;
         scan_ctrl_ff[aiss_pkg::SCAN_DIFFERENTIAL_SELECT_BIT] <= 1'b0;
      end else if (wr_ff) begin
         case (addr_ff)
            aiss_pkg::OFS_SINGLE_CTRL: single_ctrl_ff <= hwdata;
            aiss_pkg::OFS_SCAN_CTRL:
               scan_ctrl_ff[aiss_pkg::SCAN_DIFFERENTIAL_SELECT_BIT] <=
                  hwdata[aiss_pkg::SCAN_DIFFERENTIAL_SELECT_BIT];
            aiss_pkg::OFS_GROUP_MAP:   scan_group_map_ff <= hwdata;
            aiss_pkg::OFS_ENABLE_MASK: scan_enable_mask_ff <= hwdata;
            aiss_pkg::OFS_NEG_REMAP:
               scan_negative_remap_ff <= hwdata[15:0];
            aiss_pkg::OFS_MASTER_DIS:  master_dis_ff <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // start strobe, self-clearing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         scan_ctrl_ff[aiss_pkg::SCAN_START_BIT] <= 1'b0;
      else
         scan_ctrl_ff[aiss_pkg::SCAN_START_BIT] <= wr_ff &&
            addr_ff == aiss_pkg::OFS_SCAN_CTRL &&
            hwdata[aiss_pkg::SCAN_START_BIT];
   end

   // scan sequencer: walks enabled slots upward
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff   <= aiss_pkg::AISS_IDLE;
         slot_ff    <= 5'd0;
         cnt_ff     <= 4'h0;
         done_ff    <= 1'b0;
         started_ff <= 1'b0;
         result_ff  <= 17'h0_0000;
      end else begin
         case (state_ff)
            aiss_pkg::AISS_IDLE: begin
               if (scan_ctrl_ff[aiss_pkg::SCAN_START_BIT]) begin
                  state_ff <= aiss_pkg::AISS_FIND;
                  slot_ff  <= 5'd0;
                  done_ff  <= 1'b0;
               end
            end
            aiss_pkg::AISS_FIND: begin
               cnt_ff <= aiss_pkg::CONV_CYCLES;
               if (scan_enable_mask_ff[slot_ff]) begin
                  state_ff   <= aiss_pkg::AISS_CONV;
                  started_ff <= 1'b0;
               end else if (slot_ff == 5'd31) begin
                  state_ff <= aiss_pkg::AISS_IDLE;
                  done_ff  <= 1'b1;
               end else
                  slot_ff <= slot_ff + 5'd1;
            end
            aiss_pkg::AISS_CONV: begin
               // settle mux, then start, then wait for result
               if (cnt_ff != 4'h0)
                  cnt_ff <= cnt_ff - 4'h1;
               started_ff <= started_ff | (cnt_ff == 4'h1);
               if (started_ff && conv_done) begin
                  result_ff <= {slot_ff, conv_data};
                  if (slot_ff == 5'd31) begin
                     state_ff <= aiss_pkg::AISS_IDLE;
                     done_ff  <= 1'b1;
                  end else begin
                     slot_ff  <= slot_ff + 5'd1;
                     state_ff <= aiss_pkg::AISS_FIND;
                  end
               end
            end
            default: state_ff <= aiss_pkg::AISS_IDLE;
         endcase
      end
   end
   // start pulse once the mux has settled
   assign conv_start = (state_ff == aiss_pkg::AISS_CONV) &&
                       (cnt_ff == 4'h1);

   // read mux, registered into data phase
   logic [31:0] rdat;
   always_comb begin
      case (haddr[7:0])
         aiss_pkg::OFS_SINGLE_CTRL: rdat = single_ctrl_ff;
         aiss_pkg::OFS_SCAN_CTRL:
            rdat = {31'h0, scan_ctrl_ff[aiss_pkg::SCAN_DIFFERENTIAL_SELECT_BIT]};
         aiss_pkg::OFS_GROUP_MAP:   rdat = scan_group_map_ff;
         aiss_pkg::OFS_ENABLE_MASK: rdat = scan_enable_mask_ff;
         aiss_pkg::OFS_NEG_REMAP:   rdat = {16'h0, scan_negative_remap_ff};
         aiss_pkg::OFS_MASTER_DIS:  rdat = {24'h0, master_dis_ff};
         aiss_pkg::OFS_STATUS:
            rdat = {28'h0, done_ff,
                    state_ff != aiss_pkg::AISS_IDLE,
                    bus_conf_ff, neg_conf_ff};
         aiss_pkg::OFS_BUS_REQ:     rdat = {24'h0, shared_bus_req};
         aiss_pkg::OFS_RESULT:      rdat = {15'h0, result_ff};
         default:                   rdat = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (accept && !hwrite)
         hrdata <= rdat;
   end
endmodule : aiss_top

// [aiss_pkg.sv]
package aiss_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_SINGLE_CTRL  = 8'h00;
   localparam logic [7:0] OFS_SCAN_CTRL    = 8'h04;
   localparam logic [7:0] OFS_GROUP_MAP    = 8'h08;
   localparam logic [7:0] OFS_ENABLE_MASK  = 8'h0c;
   localparam logic [7:0] OFS_NEG_REMAP    = 8'h10;
   localparam logic [7:0] OFS_MASTER_DIS   = 8'h14;
   localparam logic [7:0] OFS_STATUS       = 8'h18;
   localparam logic [7:0] OFS_BUS_REQ      = 8'h1c;
   localparam logic [7:0] OFS_RESULT       = 8'h20;
   // single control fields
   localparam int POS_LSB  = 0;   // positive_input_select [7:0]
   localparam int NEG_LSB  = 8;   // negative_input_select [15:8]
   localparam int DIFFERENTIAL_SELECT_BIT = 16;  // differential_select
   // scan control fields
   localparam int SCAN_DIFFERENTIAL_SELECT_BIT  = 0;
   localparam int SCAN_START_BIT = 1;
   // status fields
   localparam int ST_NEGCONF = 0;
   localparam int ST_SHARED_BUS_CONFLICT = 1;
   localparam int ST_BUSY    = 2;
   localparam int ST_DONE    = 3;
   // input select encoding: [7:5] port (0..4), [4:0] channel; 8'hff ground
   localparam logic [7:0] SEL_GROUND   = 8'hff;
   localparam logic [7:0] SEL_INTERNAL = 8'he0;
   // reset values
   localparam logic [31:0] RST_SINGLE = 32'h0000_ff20;
   localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
   // mux settle time in cycles per slot before the start pulse
   localparam logic [3:0] CONV_CYCLES = 4'h8;
   // scan sequencer states
   typedef enum logic [1:0] {AISS_IDLE, AISS_FIND, AISS_CONV} aiss_state_t;
endpackage : aiss_pkg

// [aiss_properties.sv]
`timescale 1ns/1ps
// port-level checks on the sequencer top
module aiss_checker (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus side
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // arbitration and mux side
   input wire logic [7:0]  other_bus_req,
   input wire logic [7:0]  shared_bus_req,
   input wire logic [7:0]  shared_bus_grant,
   input wire logic [7:0]  positive_input_mux,
   input wire logic [7:0]  negative_input_mux,
   input wire logic        result_invert,
   input wire logic        conv_start
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_taken;  // read address phase accepted
   assign rd_taken = hsel && hready && htrans[1] && !hwrite;
   property p_grant_eq;
      shared_bus_grant == (shared_bus_req & ~other_bus_req);
   endproperty
   a_grant_eq: assert property (p_grant_eq) else $error("grant wrong");
   property p_float;
      (shared_bus_grant & other_bus_req) == 8'h00;
   endproperty
   a_float: assert property (p_float) else $error("contested bus");
   property p_ready;
      hreadyout;
   endproperty
   a_ready: assert property (p_ready) else $error("wait state");
   property p_resp;
      !hresp;
   endproperty
   a_resp: assert property (p_resp) else $error("error response");
   // a slot needs its conversion, a search and the settle time
   property p_start_gap;
      conv_start |=> !conv_start [*8];
   endproperty
   a_start_gap: assert property (p_start_gap) else $error("start gap");
   property p_mux_hold;
      conv_start |=> $stable(positive_input_mux)
         && $stable(negative_input_mux) && $stable(result_invert);
   endproperty
   a_mux_hold: assert property (p_mux_hold) else $error("mux moved");
   property p_reset;
      $rose(hresetn) |-> negative_input_mux == 8'hff
         && !conv_start && !result_invert;
   endproperty
   a_reset: assert property (p_reset) else $error("reset value");
   property p_rdata_hold;
      !rd_taken |=> $stable(hrdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved");
   c_start: cover property (conv_start);
endmodule : aiss_checker
bind aiss_top aiss_checker u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .other_bus_req(other_bus_req), .shared_bus_req(shared_bus_req),
   .shared_bus_grant(shared_bus_grant),
   .positive_input_mux(positive_input_mux),
   .negative_input_mux(negative_input_mux),
   .result_invert(result_invert), .conv_start(conv_start));

// [aiss_far_model.sv]
`timescale 1ns/1ps
// far side: other bus users and the converter core
module aiss_far_model (
   // clock and reset
   input wire logic         hclk,
   input wire logic         hresetn,
   // bus claims commanded by the bench
   input wire logic [7:0]   claim,
   output logic     [7:0]   other_bus_req,
   // converter handshake
   input wire logic         conv_start,
   output logic             conv_done,
   output logic     [11:0]  conv_data
);
   integer     seed = 32'h9d26;  // fixed seed
   logic [3:0] wait_ff;          // cycles left to result
   logic       busy_ff;          // conversion in flight
   // other peripherals hold their claims as levels
   assign other_bus_req = claim;
   // random latency; data flips outside done so no stale value passes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_ff   <= 1'b0;
         wait_ff   <= 4'h0;
         conv_done <= 1'b0;
         conv_data <= 12'h000;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start) begin
            busy_ff <= 1'b1;
            wait_ff <= 4'($random(seed) & 7);
         end else if (busy_ff && wait_ff == 4'h0) begin
            busy_ff   <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= 12'($random(seed));
         end else if (busy_ff) begin
            wait_ff <= wait_ff - 4'h1;
         end
      end
   end
endmodule : aiss_far_model

// [test_adc_input_scan_sequencer.sv]
`timescale 1ns/1ps
module test_adc_input_scan_sequencer;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, differential_select, inv;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, gmap, mask, remap;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, conv_start, conv_done, result_invert;
   logic [7:0]  claim = 0, other_bus_req, shared_bus_req, shared_bus_grant;
   logic [7:0]  positive_input_mux, negative_input_mux, sel;
   logic [11:0] conv_data, last_data;
   integer      error_cnt = 0, n_tests = 0, seed = 32'h9d26, n_conv = 0;
   integer      n0, last_s, k;
   aiss_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .other_bus_req(other_bus_req),
      .shared_bus_req(shared_bus_req), .shared_bus_grant(shared_bus_grant),
      .positive_input_mux(positive_input_mux),
      .negative_input_mux(negative_input_mux), .result_invert(result_invert),
      .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data));
   aiss_far_model far (.hclk(hclk), .hresetn(hresetn), .claim(claim),
      .other_bus_req(other_bus_req), .conv_start(conv_start),
      .conv_done(conv_done), .conv_data(conv_data));
   initial begin
      forever #4 hclk = ~hclk;
   end
   // track conversions and the last result handed back
   always @(posedge hclk) begin
      if (conv_done) last_data <= conv_data;
      if (conv_start) n_conv <= n_conv + 1;
   end
   task close_out;
      $display("errors %0d compares %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // single whole-word transfer, waits on ready in both phases
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // mapping: ports 1,3 even on x; ports 2,4 even on y; port 0 split
   function automatic logic is_y(input logic [7:0] s);
      if (s[7:5] == 3'h0) return s[4];
      return s[5] ? s[0] : ~s[0];
   endfunction : is_y
   function automatic logic [7:0] bus_bit(input logic [7:0] s);
      if (s[7:5] == 3'h0 || s[7:5] > 3'h4) return 8'h00;
      return 8'h01 << ((s[7:5] - 3'h1) * 2 + is_y(s));
   endfunction : bus_bit
   function automatic logic [7:0] chan(input integer s);
      logic [7:0] m;
      m = gmap[8 * (s / 8) +: 8];
      return {m[7:5], m[1:0], 3'(s % 8)};
   endfunction : chan
   function automatic logic [7:0] mate(input integer s);
      logic [1:0] r;
      r = remap[2 * (s / 2) +: 2];
      // remap overrides the default partner in both remappable groups
      if (s < 8 && s % 2 == 0 && r != 2'h0) return chan(2 * r - 1);
      if (s > 8 && s < 16 && s % 2 == 1 && r != 2'h0)
         return chan(2 * r + 6);
      if (s == 15) return chan(8);
      if (chan(s) % 32 == 31) return {chan(s) >> 5, 5'h00};
      return chan(s) + 8'h1;
   endfunction : mate
   initial begin
      repeat (50000) @(posedge hclk);
      error_cnt++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, aiss_pkg::OFS_SINGLE_CTRL, 0); cmp(rd, aiss_pkg::RST_SINGLE);
      ahb(0, aiss_pkg::OFS_ENABLE_MASK, 0); cmp(rd, aiss_pkg::RST_ZERO);
      ahb(0, 8'h40, 0); cmp(rd, 32'h0);
      for (int i = 0; i < 15; i++) begin
         sel = {3'(i % 5), 5'($random(seed))};
         ahb(1, aiss_pkg::OFS_SINGLE_CTRL, {16'h0, aiss_pkg::SEL_GROUND, sel});
         // let the register write settle before looking at the request
         @(negedge hclk);
         cmp(shared_bus_req, bus_bit(sel));
         claim <= bus_bit(sel) | 8'($random(seed));
         ahb(1, aiss_pkg::OFS_STATUS, 32'h3);
         ahb(0, aiss_pkg::OFS_STATUS, 0);
         cmp(rd & 32'h3, {30'h0, sel[7:5] != 3'h0, 1'b0});
         claim <= 8'h00;
         ahb(1, aiss_pkg::OFS_STATUS, 32'h3);
      end
      claim <= 8'h01;
      ahb(1, aiss_pkg::OFS_SINGLE_CTRL, 32'h0000_ff20);
      ahb(1, aiss_pkg::OFS_MASTER_DIS, 32'hff);
      ahb(1, aiss_pkg::OFS_STATUS, 32'h3);
      ahb(0, aiss_pkg::OFS_STATUS, 0); cmp(rd & 32'h3, 32'h0);
      cmp(shared_bus_req, 8'h00);
      ahb(1, aiss_pkg::OFS_MASTER_DIS, 0);
      claim <= 8'h00;
      ahb(1, aiss_pkg::OFS_SINGLE_CTRL, 32'h0001_2220);
      ahb(1, aiss_pkg::OFS_STATUS, 32'h1);
      ahb(0, aiss_pkg::OFS_STATUS, 0); cmp(rd & 32'h1, 32'h1);
      ahb(1, aiss_pkg::OFS_SINGLE_CTRL, 32'h0001_2120);
      ahb(1, aiss_pkg::OFS_STATUS, 32'h1);
      ahb(0, aiss_pkg::OFS_STATUS, 0); cmp(rd & 32'h1, 32'h0);
      for (int run = 0; run < 6; run++) begin
         differential_select = run[0];
         for (int g = 0; g < 4; g++)
            gmap[8 * g +: 8] = {3'($unsigned($random(seed)) % 4 + 1), 3'h0,
                                2'($random(seed))};
         if (run < 2) gmap[1:0] = 2'h3;
         mask = $random(seed) | 32'h0000_8081;
         if (run == 5) mask = 0;
         remap = $random(seed) & 32'hffff;
         ahb(1, aiss_pkg::OFS_GROUP_MAP, gmap);
         ahb(1, aiss_pkg::OFS_ENABLE_MASK, mask);
         ahb(1, aiss_pkg::OFS_NEG_REMAP, remap);
         n0 = n_conv;
         ahb(1, aiss_pkg::OFS_SCAN_CTRL, {30'h0, 1'b1, differential_select});
         for (int s = 0; s < 32; s++) if (mask[s]) begin
            k = 0;
            do begin
               @(negedge hclk);
               k++;
            end while (conv_start !== 1'b1 && k < 200);
            sel = differential_select ? mate(s) : aiss_pkg::SEL_GROUND;
            // a y positive input lands on the negative mux, result inverted
            inv = is_y(chan(s)) && !(differential_select && is_y(sel));
            cmp(positive_input_mux, inv ? sel : chan(s));
            cmp(negative_input_mux, inv ? chan(s) : sel);
            cmp(result_invert, inv);
            last_s = s;
         end
         k = 0;
         do begin
            ahb(0, aiss_pkg::OFS_STATUS, 0);
            k++;
         end while (rd[2] !== 1'b0 && k < 100);
         cmp(rd & 32'h8, 32'h8);
         cmp(n_conv - n0, $countones(mask));
         ahb(0, aiss_pkg::OFS_RESULT, 0);
         if (mask != 0) cmp(rd, {15'h0, 5'(last_s), last_data});
      end
      close_out();
   end
endmodule : test_adc_input_scan_sequencer
